/* include/pcs_pkg.sv */
// package for the configuration command/status register bank
// Operation
// - command bit 0 writable, reset 0; when 0 no I/O space response
// - command bit 1 writable, reset 0; when 0 memory space ignored
// - command bit 2 enables initiator; read-only zero without initiator
// - command bits 3,4,5,7,9 and 15:11 read as zero
// - command bit 6 writable, reset 0; gates parity error response
// - command bit 8 writable, reset 0; when 0 system-error driver disabled
// - command bit 10 writable, reset 0; when set interrupt never asserted
// - status bit 3 mirrors the current interrupt output state
// - status bit 4 reads constant one, capability list present
// - status bit 5 is build parameter: 1 fast, 0 normal speed
// - status bits 2:0,6,7 zero; bits 10:9 read binary 10
// - status bit 8 set on initiator parity error report; write one clears
// - status bit 11 set on signalled target abort; write one clears
// - status bit 12 set on received target abort; write one clears
// - status bit 13 set on master abort; write one clears
// - status bit 14 set when system error asserted; write one clears
// - status bit 15 set on any parity error regardless of bit 6
// - identification, class, subsystem, latency, grant fields from parameters
package pcs_pkg;
   // ------------------------------------------------------------
   // offsets and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] PCS_OFF_ID      = 8'h00;
   localparam logic [7:0] PCS_OFF_CMDSTAT = 8'h04;
   localparam logic [7:0] PCS_OFF_CLASS   = 8'h08;
   localparam logic [7:0] PCS_OFF_SUBSYS  = 8'h2c;
   localparam logic [7:0] PCS_OFF_INTR    = 8'h3c;
   localparam int CMD_IO     = 0;
   localparam int CMD_MEM    = 1;
   localparam int CMD_MASTER = 2;
   localparam int CMD_PERR   = 6;
   localparam int CMD_SERR   = 8;
   localparam int CMD_INTDIS = 10;
   localparam int ST_INT     = 3;
   localparam int ST_CAP     = 4;
   localparam int ST_FAST    = 5;
   localparam int ST_DPERR   = 8;
   localparam int ST_STA     = 11;
   localparam int ST_RTA     = 12;
   localparam int ST_RMA     = 13;
   localparam int ST_SSE     = 14;
   localparam int ST_DPE     = 15;
   localparam logic [1:0]  PCS_DEVSEL_SLOW = 2'h2;
   localparam logic [15:0] PCS_CMD_RESET   = 16'h0000;
   localparam logic [15:0] PCS_CMD_WMASK   = 16'h0547;
   localparam logic [15:0] PCS_ST_W1C_MASK = 16'hf900;
   localparam logic [15:0] PCS_ST_RESET    = 16'h0000;
   localparam logic [7:0]  PCS_INT_PIN     = 8'h01;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pcs_cfg_req_t;

   typedef struct packed {
      logic perr_seen;
      logic tabort_sig;
      logic tabort_rcv;
      logic mabort;
      logic serr_sig;
      logic parity_err;
   } pcs_evt_t;

   typedef struct packed {
      logic io_en;
      logic mem_en;
      logic master_en;
      logic perr_resp;
      logic serr_en;
      logic int_dis;
   } pcs_ctl_t;
endpackage : pcs_pkg

/* logic/pcs_w1c_flag.sv */
// one write-one-to-clear status flag
`timescale 1ns/1ps
module pcs_w1c_flag #(
   parameter bit PRESENT = 1'b1
) (
   input  wire logic clk_sys_in,
   input  wire logic srst_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   output logic      flag_out
);
   always_ff @(posedge clk_sys_in) begin
      if (srst_in || !PRESENT) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule : pcs_w1c_flag

/* logic/pcs_cmd_status.sv */
// configuration header command/status register bank
`timescale 1ns/1ps
module pcs_cmd_status
   import pcs_pkg::*;
#(
   parameter bit          HAS_MASTER             = 1'b1,
   parameter bit          fast_bus_capable_param = 1'b0,
   parameter logic [15:0] VENDOR_ID_P            = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_ID_P            = 16'h0001, // arbitrary value
   parameter logic [7:0]  REVISION_ID_P          = 8'h00,    // arbitrary value
   parameter logic [23:0] CLASS_CODE_P           = 24'h118000,
   parameter logic [15:0] SUBSYS_ID_P            = 16'h0000, // arbitrary value
   parameter logic [15:0] SUBSYS_VENDOR_ID_P     = 16'h0000, // arbitrary value
   parameter logic [7:0]  MAX_LAT_P              = 8'h00,
   parameter logic [7:0]  MIN_GNT_P              = 8'h00
) (
   input  wire logic         clk_sys_in,
   input  wire logic         srst_in,
   input  wire pcs_cfg_req_t cfg_req_in,
   input  wire pcs_evt_t     evt_in,
   input  wire logic         int_req_in,
   input  wire logic         serr_req_in,
   input  wire logic         perr_req_in,
   output logic [31:0]       cfg_rdata_out,
   output logic              cfg_rvalid_out,
   output pcs_ctl_t          ctl_out,
   output logic              int_active_out,
   output logic              serr_oe_out,
   output logic              perr_oe_out
);
   // ------------------------------------------------------------
   // command register
   // ------------------------------------------------------------
   logic [15:0] cmd;
   logic        hit_cs;
   logic [15:0] cmd_wmask;
   logic [15:0] next_cmd;

   assign hit_cs    = cfg_req_in.wr && (cfg_req_in.addr == PCS_OFF_CMDSTAT);
   assign cmd_wmask = HAS_MASTER ? PCS_CMD_WMASK
                                 : (PCS_CMD_WMASK & ~(16'h0001 << CMD_MASTER));

   always_comb begin
      next_cmd = cmd;
      if (cfg_req_in.be[0]) begin
         next_cmd[7:0] = cfg_req_in.wdata[7:0];
      end
      if (cfg_req_in.be[1]) begin
         next_cmd[15:8] = cfg_req_in.wdata[15:8];
      end
      next_cmd = next_cmd & cmd_wmask;
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cmd <= PCS_CMD_RESET;
      end else if (hit_cs) begin
         cmd <= next_cmd;
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   logic [15:0] clr_req;
   logic [15:0] flags;
   logic [5:0]  flag_set;
   logic [5:0]  flag_q;
   logic [5:0]  flag_clr;

   assign clr_req  = (hit_cs && cfg_req_in.be[3]) ? {cfg_req_in.wdata[31:24], 8'h00}
                                                  : 16'h0000;
   assign flag_set = {evt_in.parity_err, evt_in.serr_sig, evt_in.mabort,
                      evt_in.tabort_rcv, evt_in.tabort_sig, evt_in.perr_seen};
   assign flag_clr = {clr_req[ST_DPE], clr_req[ST_SSE], clr_req[ST_RMA],
                      clr_req[ST_RTA], clr_req[ST_STA], clr_req[ST_DPERR]};

   pcs_w1c_flag #(.PRESENT(HAS_MASTER)) u_dperr (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[0]),
      .clr_in     (flag_clr[0]),
      .flag_out   (flag_q[0])
   );
   pcs_w1c_flag #(.PRESENT(1'b1)) u_sta (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[1]),
      .clr_in     (flag_clr[1]),
      .flag_out   (flag_q[1])
   );
   pcs_w1c_flag #(.PRESENT(HAS_MASTER)) u_rta (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[2]),
      .clr_in     (flag_clr[2]),
      .flag_out   (flag_q[2])
   );
   pcs_w1c_flag #(.PRESENT(HAS_MASTER)) u_rma (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[3]),
      .clr_in     (flag_clr[3]),
      .flag_out   (flag_q[3])
   );
   pcs_w1c_flag #(.PRESENT(1'b1)) u_sse (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[4]),
      .clr_in     (flag_clr[4]),
      .flag_out   (flag_q[4])
   );
   pcs_w1c_flag #(.PRESENT(1'b1)) u_dpe (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .set_in     (flag_set[5]),
      .clr_in     (flag_clr[5]),
      .flag_out   (flag_q[5])
   );

   // ------------------------------------------------------------
   // gated outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         int_active_out <= 1'b0;
         serr_oe_out    <= 1'b0;
         perr_oe_out    <= 1'b0;
         ctl_out        <= '0;
      end else begin
         int_active_out <= int_req_in && !cmd[CMD_INTDIS];
         serr_oe_out    <= serr_req_in && cmd[CMD_SERR] && cmd[CMD_PERR];
         perr_oe_out    <= perr_req_in && cmd[CMD_PERR];
         ctl_out.io_en     <= cmd[CMD_IO];
         ctl_out.mem_en    <= cmd[CMD_MEM];
         ctl_out.master_en <= cmd[CMD_MASTER];
         ctl_out.perr_resp <= cmd[CMD_PERR];
         ctl_out.serr_en   <= cmd[CMD_SERR];
         ctl_out.int_dis   <= cmd[CMD_INTDIS];
      end
   end

   // ------------------------------------------------------------
   // status word assembly
   // ------------------------------------------------------------
   logic [15:0] status;

   always_comb begin
      status              = PCS_ST_RESET;
      status[ST_INT]      = int_active_out;
      status[ST_CAP]      = 1'b1;
      status[ST_FAST]     = fast_bus_capable_param;
      status[10:9]        = PCS_DEVSEL_SLOW;
      status[ST_DPERR]    = flag_q[0];
      status[ST_STA]      = flag_q[1];
      status[ST_RTA]      = flag_q[2];
      status[ST_RMA]      = flag_q[3];
      status[ST_SSE]      = flag_q[4];
      status[ST_DPE]      = flag_q[5];
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb begin
      case (cfg_req_in.addr)
         PCS_OFF_ID:      next_rdata = {DEVICE_ID_P, VENDOR_ID_P};
         PCS_OFF_CMDSTAT: next_rdata = {status, cmd};
         PCS_OFF_CLASS:   next_rdata = {CLASS_CODE_P, REVISION_ID_P};
         PCS_OFF_SUBSYS:  next_rdata = {SUBSYS_ID_P, SUBSYS_VENDOR_ID_P};
         PCS_OFF_INTR:    next_rdata = {MAX_LAT_P, MIN_GNT_P, PCS_INT_PIN, 8'h00};
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cfg_rdata_out  <= 32'h0000_0000;
         cfg_rvalid_out <= 1'b0;
      end else begin
         cfg_rvalid_out <= cfg_req_in.rd;
         if (cfg_req_in.rd) begin
            cfg_rdata_out <= next_rdata;
         end
      end
   end
endmodule : pcs_cmd_status

/* verification/pcs_cmd_status_properties.sv */
// assertions on the command/status bank ports
`timescale 1ns/1ps
module pcs_cmd_status_properties
   import pcs_pkg::*;
(
   input wire logic         clk_sys_in,
   input wire logic         srst_in,
   input wire pcs_cfg_req_t cfg_req_in,
   input wire pcs_evt_t     evt_in,
   input wire logic [31:0]  cfg_rdata_out,
   input wire logic         cfg_rvalid_out,
   input wire pcs_ctl_t     ctl_out,
   input wire logic         int_active_out,
   input wire logic         serr_oe_out,
   input wire logic         perr_oe_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   wire        w04 = cfg_req_in.wr && cfg_req_in.addr == 8'h04 && cfg_req_in.be[0];
   wire        r04 = cfg_req_in.rd && cfg_req_in.addr == 8'h04;
   wire [31:0] wd  = cfg_req_in.wdata;
   wire [31:0] rd  = cfg_rdata_out;
   property p_io; w04 |-> ##2 ctl_out.io_en == $past(wd[0], 2); endproperty
   a_io: assert property (p_io) else $error("io enable wrong");
   property p_mem; w04 |-> ##2 ctl_out.mem_en == $past(wd[1], 2); endproperty
   a_mem: assert property (p_mem) else $error("memory enable wrong");
   property p_int; ctl_out.int_dis |-> !int_active_out; endproperty
   a_int: assert property (p_int) else $error("interrupt while disabled");
   property p_serr; !ctl_out.serr_en |-> !serr_oe_out; endproperty
   a_serr: assert property (p_serr) else $error("system error driven");
   property p_perr; !ctl_out.perr_resp |-> !perr_oe_out; endproperty
   a_perr: assert property (p_perr) else $error("parity error driven");
   property p_ro; r04 |=> cfg_rvalid_out && (rd & 32'h06d7_fab8) == 32'h0410_0000; endproperty
   a_ro: assert property (p_ro) else $error("fixed bits wrong");
   property p_mir; r04 |=> rd[19] == $past(int_active_out); endproperty
   a_mir: assert property (p_mir) else $error("interrupt status wrong");
   property p_dpe; evt_in.parity_err ##1 r04 |=> rd[31]; endproperty
   a_dpe: assert property (p_dpe) else $error("parity flag not set");
   property p_sta; evt_in.tabort_sig ##1 r04 |=> rd[27]; endproperty
   a_sta: assert property (p_sta) else $error("abort flag not set");
endmodule : pcs_cmd_status_properties

bind pcs_cmd_status pcs_cmd_status_properties i_props (
   .clk_sys_in, .srst_in, .cfg_req_in, .evt_in, .cfg_rdata_out, .cfg_rvalid_out,
   .ctl_out, .int_active_out, .serr_oe_out, .perr_oe_out
);

/* verification/pcs_host_model.sv */
// configuration-cycle master standing in for the host bridge
`timescale 1ns/1ps
module pcs_host_model
   import pcs_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic [31:0] cfg_rdata_out,
   input  wire logic        cfg_rvalid_out,
   output pcs_cfg_req_t     cfg_req_out
);
   initial cfg_req_out = '0;
   task automatic put(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      @(negedge clk_sys_in);
      cfg_req_out = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
   endtask : put
   // released bus shows inverted leftovers
   task automatic idle();
      @(negedge clk_sys_in);
      cfg_req_out = '{1'b0, 1'b0, ~cfg_req_out.addr, 4'h0, ~cfg_req_out.wdata};
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      put(1'b1, a, b, d);
      idle();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
      put(1'b0, a, 4'hf, 32'h0);
      idle();
      d = cfg_rdata_out;
      v = cfg_rvalid_out;
   endtask : rd
endmodule : pcs_host_model

/* verification/tb.sv */
// self-checking bench for the command/status bank
`timescale 1ns/1ps
module tb
   import pcs_pkg::*;
;
   localparam logic [15:0] ST0 = 16'h0430;
   logic         clk_sys_in = 1'b0;
   logic         srst_in = 1'b1;
   logic         int_req_in = 1'b0;
   logic         serr_req_in = 1'b0;
   logic         perr_req_in = 1'b0;
   pcs_evt_t     evt_in = '0;
   pcs_cfg_req_t cfg_req_in;
   logic [31:0]  cfg_rdata_out;
   logic         cfg_rvalid_out, int_active_out, serr_oe_out, perr_oe_out;
   pcs_ctl_t     ctl_out;
   int           n_errors = 0;
   int           checks = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   pcs_cmd_status #(.fast_bus_capable_param(1'b1)) i_dut (.clk_sys_in, .srst_in, .cfg_req_in,
      .evt_in, .int_req_in, .serr_req_in, .perr_req_in, .cfg_rdata_out, .cfg_rvalid_out,
      .ctl_out, .int_active_out, .serr_oe_out, .perr_oe_out);
   pcs_host_model i_host (.clk_sys_in, .cfg_rdata_out, .cfg_rvalid_out,
      .cfg_req_out(cfg_req_in));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        v;
      i_host.rd(a, d, v);
      chk({nm, " valid"}, 32'(v), 32'h1);
      chk(nm, d, exp);
   endtask : rd_chk
   task automatic set_cmd(input logic [15:0] c);
      i_host.wr(8'h04, 4'h3, {16'hffff, c});
      @(negedge clk_sys_in);
   endtask : set_cmd
   task automatic t_cmd();
      rd_chk("reset", 8'h04, {ST0, 16'h0});
      rd_chk("id", 8'h00, 32'h0001_1234);
      set_cmd(16'hffff);
      rd_chk("cmd ones", 8'h04, {ST0, 16'h0547});
      chk("ctl on", 32'(ctl_out), 32'h3f);
      set_cmd(16'h0000);
      chk("ctl off", 32'(ctl_out), 32'h0);
      $display("test cmd done");
   endtask : t_cmd
   task automatic t_int();
      int_req_in = 1'b1;
      @(negedge clk_sys_in);
      chk("int on", 32'(int_active_out), 32'h1);
      rd_chk("int mirror", 8'h04, {ST0 | 16'h0008, 16'h0});
      set_cmd(16'h0400);
      chk("int off", 32'(int_active_out), 32'h0);
      rd_chk("off mirror", 8'h04, {ST0, 16'h0400});
      int_req_in = 1'b0;
      $display("test int done");
   endtask : t_int
   task automatic t_oe();
      logic [15:0] tbl[4] = '{16'h0040, 16'h0140, 16'h0100, 16'h0000};
      serr_req_in = 1'b1;
      perr_req_in = 1'b1;
      foreach (tbl[i]) begin
         set_cmd(tbl[i]);
         chk("perr oe", 32'(perr_oe_out), 32'(tbl[i][6]));
         chk("serr oe", 32'(serr_oe_out), 32'(tbl[i][8] & tbl[i][6]));
      end
      $display("test oe done");
   endtask : t_oe
   task automatic t_flags();
      int          sb[6] = '{15, 14, 13, 12, 11, 8};
      logic [15:0] f;
      for (int k = 0; k < 6; k++) begin
         f = ST0 | (16'h1 << sb[k]);
         evt_in = pcs_evt_t'(6'h1 << k);
         rd_chk("set", 8'h04, {f, 16'h0});
         evt_in = '0;
         i_host.wr(8'h04, 4'hc, 32'h0);
         rd_chk("kept", 8'h04, {f, 16'h0});
         i_host.put(1'b1, 8'h04, 4'hc, 32'hffff_0000);
         evt_in = pcs_evt_t'(6'h1 << k);
         i_host.idle();
         evt_in = '0;
         rd_chk("set wins", 8'h04, {f, 16'h0});
         i_host.wr(8'h04, 4'h8, 32'hff00_0000);
         rd_chk("cleared", 8'h04, {ST0, 16'h0});
      end
      $display("test flags done");
   endtask : t_flags
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial begin
      repeat (6) @(negedge clk_sys_in);
      srst_in = 1'b0;
      t_cmd();
      t_int();
      t_oe();
      t_flags();
      final_report();
   end
   initial begin
      repeat (3000) @(posedge clk_sys_in);
      n_errors++;
      final_report();
   end
endmodule : tb
